// file: logic/dsasc_pkg.sv
// package: timing constants and request/pin carriers for the sram host
`default_nettype none
package dsasc_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 11;                // 2048 locations
   localparam int DATA_W = 8;                 // byte wide
   // ----------------------------------------------------------------
   // clock and times in ns
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS             = 5;
   localparam int ADDR_LEAD_BEFORE_WRITE_NS = 20;   // address to overlap
   localparam int ADDR_VALID_TO_WRITE_END_NS= 130;
   localparam int SEL_A_TO_WRITE_END_NS     = 100;
   localparam int SEL_B_TO_WRITE_END_NS     = 110;
   localparam int WRITE_PULSE_NS            = 100;  // overlap length
   localparam int DATA_SETUP_TO_WRITE_END_NS= 50;
   localparam int DATA_HOLD_AFTER_WRITE_NS  = 20;
   localparam int WRITE_RECOVERY_NS         = 15;
   localparam int SELECT_TO_VALID_NS        = 150;  // read access, max
   localparam int MIN_READ_CYCLE_NS         = 150;
   localparam int STROBE_TO_FLOAT_NS        = 60;   // device release, max
   localparam int DESELECT_TO_FLOAT_NS      = 70;
   // least times round up to whole cycles
   function automatic int ceil_cyc(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction
   localparam int AS_CYC  = ceil_cyc(ADDR_LEAD_BEFORE_WRITE_NS);
   localparam int WP_CYC  = ceil_cyc(ADDR_VALID_TO_WRITE_END_NS
                                     - ADDR_LEAD_BEFORE_WRITE_NS);
   localparam int DH_CYC  = ceil_cyc(DATA_HOLD_AFTER_WRITE_NS);
   localparam int WR_CYC  = ceil_cyc(WRITE_RECOVERY_NS);
   localparam int RD_CYC  = ceil_cyc(SELECT_TO_VALID_NS) + 1;
   localparam int FLT_CYC = ceil_cyc(DESELECT_TO_FLOAT_NS);
   localparam int CYC_CYC = ceil_cyc(MIN_READ_CYCLE_NS);
   localparam int CNT_W   = 8;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              write;   // 1 = write, 0 = read
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dsasc_req_t;
   typedef struct packed {
      logic                select_primary_n;
      logic                select_secondary_n;
      logic                write_strobe_n;
      logic [ADDR_W-1:0]   addr;
   } dsasc_pins_t;
endpackage
`default_nettype wire

// file: logic/dsasc_host.sv
// host controller driving a dual-select asynchronous 2k x 8 static memory
//
// Operation
// [R01] memory is 2048 bytes, eleven-bit address
// [R02] read: both selects low, strobe high
// [R03] write overlap of all three lows, 100 ns
// [R04] select with strobe keeps device outputs floating
// [R05] never drive data while device drives
// [R06] driven outputs echo applied write data
// [R07] after write, next address reads back
// [R08] device resumes driving 10 ns after write
// [R09] address stable 20 ns before overlap
// [R10] address valid 130 ns before write end
// [R11] selects low 100/110 ns before end
// [R12] write data valid 50 ns before end
// [R13] write data held 20 ns after end
// [R14] wait 15 ns after rise before next
// [R15] device floats within 60 ns of strobe
// [R16] read data valid 150 ns after select
// [R17] device drives no earlier than 10 ns
// [R18] deselect floats outputs within 70 ns
// [R19] old data held 15 ns after address
// [R20] cycles spaced at least 150 ns apart
`timescale 1ns/100ps
`default_nettype none
module dsasc_host #(
   parameter int ADDR_W = dsasc_pkg::ADDR_W,
   parameter int DATA_W = dsasc_pkg::DATA_W
) (
   input  wire logic                 clock_in,
   input  wire logic                 sys_rst_in,
   // user request side
   input  wire logic                 req_valid_in,
   input  wire dsasc_pkg::dsasc_req_t req_in,
   output logic                      req_ready_out,
   output logic                      rd_valid_out,
   output logic [DATA_W-1:0]         rd_data_out,
   // memory pins
   output dsasc_pkg::dsasc_pins_t    pins_out,
   input  wire logic [DATA_W-1:0]    data_in,
   output logic [DATA_W-1:0]         data_out,
   output logic                      data_oe_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE,    // ready for a request
      S_RD,      // selects low, waiting out the access time
      S_WSET,    // address and data settle before the overlap
      S_WPULSE,  // write overlap open
      S_WHOLD,   // data held after the overlap closes
      S_FLOAT,   // device outputs given time to float
      S_GAP      // pad to the least cycle time
   } dsasc_state_t;

   dsasc_state_t                 state_reg;    // sequencer state
   logic [dsasc_pkg::CNT_W-1:0]  cnt_reg;      // cycles left in phase
   logic [dsasc_pkg::CNT_W-1:0]  cyc_reg;      // cycles since cycle start
   logic [ADDR_W-1:0]            addr_reg;     // held address
   logic [DATA_W-1:0]            wdata_reg;    // held write data
   logic                         sel_n_reg;    // both selects together
   logic                         we_n_reg;     // write strobe
   logic                         oe_reg;       // our data drive enable

   // cycle counts cut to the counter width
   function automatic logic [dsasc_pkg::CNT_W-1:0] cyc(input int n);
      return n[dsasc_pkg::CNT_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // handshake and pin drive
   // ----------------------------------------------------------------
   // ready only in idle: one cycle in flight keeps the pin timing simple
   assign req_ready_out = (state_reg == S_IDLE);
   // one assignment for the whole pin group: both selects move as one
   assign pins_out = '{select_primary_n:   sel_n_reg,
                       select_secondary_n: sel_n_reg,
                       write_strobe_n:     we_n_reg,
                       addr:               addr_reg};   // R01
   assign data_out    = wdata_reg;
   assign data_oe_out = oe_reg;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // selects and strobe fall in one cycle so the device never drives
   // during a write, hence our drive never meets its outputs
   // limitation: only one access is in flight, so back to back bytes
   // each cost a full least cycle time
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_reg <= S_IDLE;
         cnt_reg   <= '0;
         sel_n_reg <= 1'b1;
         we_n_reg  <= 1'b1;
         oe_reg    <= 1'b0;
      end else begin
         // phase counter runs down and rests at zero
         cnt_reg <= (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
         case (state_reg)
            // wait for a request
            S_IDLE: begin
               if (req_valid_in) begin
                  if (req_in.write) begin
                     // address settles before the overlap opens
                     state_reg <= S_WSET;                         // R09
                     cnt_reg   <= cyc(dsasc_pkg::AS_CYC - 1);
                     oe_reg    <= 1'b1;  // selects still high: safe R05
                  end else begin
                     state_reg <= S_RD;
                     sel_n_reg <= 1'b0;                           // R02
                     cnt_reg   <= cyc(dsasc_pkg::RD_CYC - 1);     // R16
                  end
               end
            end
            // read: wait the worst access, then sample
            S_RD: begin
               if (cnt_reg == '0) begin
                  sel_n_reg <= 1'b1;                              // R18
                  state_reg <= S_FLOAT;
                  cnt_reg   <= cyc(dsasc_pkg::FLT_CYC - 1);
               end
            end
            // address and data settle, then open the overlap
            S_WSET: begin
               if (cnt_reg == '0) begin
                  sel_n_reg <= 1'b0;   // together with strobe: R04
                  we_n_reg  <= 1'b0;                              // R03
                  state_reg <= S_WPULSE;
                  cnt_reg   <= cyc(dsasc_pkg::WP_CYC - 1);   // R10 R11 R12
               end
            end
            // overlap held; covers 100/110 ns selects and 50 ns data
            S_WPULSE: begin
               if (cnt_reg == '0) begin
                  sel_n_reg <= 1'b1;   // deselect ends write, no echo
                  we_n_reg  <= 1'b1;
                  state_reg <= S_WHOLD;
                  cnt_reg   <= cyc(dsasc_pkg::DH_CYC - 1);
               end
            end
            // data stays on the bus after the overlap ends; our drive
            // drops only once the selects are already high
            S_WHOLD: begin
               if (cnt_reg == '0) begin
                  oe_reg    <= 1'b0;                              // R13
                  state_reg <= S_GAP;
                  cnt_reg   <= cyc(dsasc_pkg::WR_CYC - 1);        // R14
               end
            end
            // let the device bus float after a read
            S_FLOAT: begin
               if (cnt_reg == '0) begin
                  state_reg <= S_GAP;
               end
            end
            // pad the whole cycle out to the least cycle time; the
            // phase counter also covers the short tail of a write
            S_GAP: begin
               if (cnt_reg == '0 &&
                   cyc_reg >= cyc(dsasc_pkg::CYC_CYC)) begin      // R20
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               sel_n_reg <= 1'b1;
               we_n_reg  <= 1'b1;
               oe_reg    <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // cycle length counter
   // ----------------------------------------------------------------
   // saturates so long gaps never wrap back below the least cycle;
   // cleared in idle so it measures from the take edge
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         cyc_reg <= '0;
      end else if (state_reg == S_IDLE) begin
         cyc_reg <= '0;
      end else if (cyc_reg != '1) begin
         cyc_reg <= cyc_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // address and write data capture
   // ----------------------------------------------------------------
   // latched on the take edge; the pins then stay put for the whole
   // cycle, which gives reads their address hold for free
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else if (state_reg == S_IDLE && req_valid_in) begin
         addr_reg  <= req_in.addr;
         wdata_reg <= req_in.wdata;
      end
   end

   // ----------------------------------------------------------------
   // read data return
   // ----------------------------------------------------------------
   // sampled on the last selected cycle, past the access time; the
   // byte is taken at the edge that raises the selects, so the
   // device's hold after deselect is never relied on
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rd_valid_out <= 1'b0;
         rd_data_out  <= '0;
      end else begin
         rd_valid_out <= 1'b0;
         if (state_reg == S_RD && cnt_reg == '0) begin
            rd_valid_out <= 1'b1;                                 // R16
            rd_data_out  <= data_in;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/dsasc_host_sva.sv
// checker: pin timing of the sram host
`timescale 1ns/100ps
`default_nettype none
module dsasc_host_sva (
   input wire logic                   clock_in,
   input wire logic                   sys_rst_in,
   input wire logic                   rd_valid_out,
   input wire dsasc_pkg::dsasc_pins_t pins_out,
   input wire logic [7:0]             data_out,
   input wire logic                   data_oe_out
);
   wire logic sel = !pins_out.select_primary_n && !pins_out.select_secondary_n;
   wire logic rd  = sel && pins_out.write_strobe_n;   // read phase
   wire logic wr  = sel && !pins_out.write_strobe_n;  // write overlap
   logic [10:0] last_reg;                              // address last cycle
   logic [7:0]  dlast_reg;                             // data last cycle
   logic [7:0]  rcnt_reg, wcnt_reg, scnt_reg, acnt_reg, dcnt_reg, gcnt_reg;
   // run lengths; the long ones saturate so idle never wraps
   always_ff @(posedge clock_in) begin
      last_reg  <= pins_out.addr;
      dlast_reg <= data_out;
      rcnt_reg  <= rd ? rcnt_reg + 8'h01 : 8'h00;
      wcnt_reg  <= wr ? wcnt_reg + 8'h01 : 8'h00;
      scnt_reg  <= pins_out.select_secondary_n ? 8'h00 : scnt_reg + 8'h01;
      acnt_reg  <= sys_rst_in ? 8'h00
                   : (pins_out.addr != last_reg) ? 8'h00
                   : acnt_reg + {7'h00, acnt_reg != 8'hFF};
      dcnt_reg  <= (!data_oe_out || data_out != dlast_reg) ? 8'h00
                   : dcnt_reg + {7'h00, dcnt_reg != 8'hFF};
      gcnt_reg  <= sys_rst_in ? 8'hFF
                   : $fell(pins_out.select_primary_n) ? 8'h00
                   : gcnt_reg + {7'h00, gcnt_reg != 8'hFF};
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   a_read_access: assert property ($fell(rd) |->
      rcnt_reg >= 8'h1E && rd_valid_out) else $error("short read");
   a_write_width: assert property ($fell(wr) |->
      wcnt_reg >= 8'h14) else $error("short write overlap");
   a_sel_lead: assert property ($fell(wr) |->
      scnt_reg >= 8'h16) else $error("select low too short");
   a_addr_setup: assert property ($rose(wr) |->
      acnt_reg >= 8'h03) else $error("address setup short");
   a_addr_valid: assert property ($fell(wr) |->
      acnt_reg >= 8'h19) else $error("address valid short");
   a_data_setup: assert property ($fell(wr) |->
      dcnt_reg >= 8'h09) else $error("data setup short");
   a_data_hold: assert property ($fell(wr) |->
      (data_oe_out && $stable(data_out))[*4]) else $error("data hold short");
   a_no_clash: assert property (rd |-> !data_oe_out)
      else $error("host drives during read");
   a_write_recover: assert property ($rose(pins_out.select_primary_n) |->
      pins_out.select_primary_n[*3]) else $error("recovery short");
   a_cycle_gap: assert property ($fell(pins_out.select_primary_n) |->
      gcnt_reg >= 8'h1D) else $error("cycles too close");
   c_read: cover property (rd_valid_out);
   c_write: cover property ($fell(wr));
   c_recover: cover property ($rose(pins_out.select_primary_n));
endmodule
bind dsasc_host dsasc_host_sva u_sva (.clock_in(clock_in),
   .sys_rst_in(sys_rst_in), .rd_valid_out(rd_valid_out),
   .pins_out(pins_out), .data_out(data_out), .data_oe_out(data_oe_out));
`default_nettype wire

// file: tb/dsasc_sram_model.sv
// behavioural 2k x 8 memory with two selects, resolves the shared bus
`timescale 1ns/100ps
`default_nettype none
module dsasc_sram_model (
   input wire dsasc_pkg::dsasc_pins_t pins_in,
   input wire logic                   host_oe_in,
   input wire logic [7:0]             host_data_in,
   output logic [7:0]                 bus_out
);
   logic [7:0] mem [0:2047];  // 2048 bytes
   logic       drv, valid;    // outputs on, data settled
   logic [7:0] last;          // released bus shows its inverse
   logic [7:0] q;             // byte behind the output drivers
   // decoded straight from the pins so no race between two derived
   // nets can fake a read edge when a write opens or closes
   wire logic rd = !pins_in.select_primary_n && !pins_in.select_secondary_n
      && pins_in.write_strobe_n;
   wire logic wr = !pins_in.select_primary_n && !pins_in.select_secondary_n
      && !pins_in.write_strobe_n;
   initial begin
      drv = 0;
      valid = 0;
      last = 8'h00;
      q = 8'h00;
      for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5A;
   end
   // old byte stands 15 ns after an address move, then the new one
   always @(pins_in.addr) #15 q = mem[pins_in.addr];
   // garbage until access time, so a hasty sample fails; a write that
   // ends with selects low turns the outputs back on the same way
   always @(posedge rd) begin
      valid = 0;
      #10 drv = rd;
      #135 valid = rd;
   end
   // strobe fall or deselect floats the outputs after 20 ns
   always @(negedge rd) begin
      #20 drv = 0;
      valid = 0;
   end
   always @(negedge wr) begin
      mem[pins_in.addr] = bus_out;
      q = bus_out;
   end
   // an applied write byte is what the pins show
   assign bus_out = host_oe_in ? host_data_in : drv ? (valid ?
      q : ~q) : ~last;
   always @(bus_out) if (host_oe_in || drv) last = bus_out;
endmodule
`default_nettype wire

// file: tb/tb.sv
// testbench: host against the behavioural memory
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clock_in, sys_rst_in, req_valid_in, req_ready_out, rd_valid_out;
   logic data_oe_out;
   logic [7:0] rd_data_out, data_out, bus;
   dsasc_pkg::dsasc_req_t  req_in;
   dsasc_pkg::dsasc_pins_t pins_out;
   int n_fail, cmp_count, cyc;
   dsasc_host dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .req_valid_in(req_valid_in), .req_in(req_in),
      .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out), .pins_out(pins_out), .data_in(bus),
      .data_out(data_out), .data_oe_out(data_oe_out));
   dsasc_sram_model u_mem (.pins_in(pins_out), .host_oe_in(data_oe_out),
      .host_data_in(data_out), .bus_out(bus));
   initial begin
      clock_in = 0;
      forever #2.5 clock_in = ~clock_in;
   end
   task automatic results;
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles needed
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until an edge that sees ready high
   task automatic issue(input logic w, input logic [10:0] a,
                        input logic [7:0] d);
      @(posedge clock_in);
      req_valid_in <= 1'b1;
      req_in <= '{write: w, addr: a, wdata: d};
      do @(negedge clock_in); while (req_ready_out !== 1'b1);
      @(posedge clock_in);
      req_valid_in <= 1'b0;
   endtask
   task automatic rd_chk(input logic [10:0] a, input logic [7:0] e);
      int n;
      n = 0;
      issue(1'b0, a, 8'h00);
      while (rd_valid_out !== 1'b1 && n < 60) begin
         @(negedge clock_in);
         n++;
      end
      chk("rd_latency", 8'h20, n[7:0]);
      chk("rd_data_out", e, rd_data_out);
   endtask
   task automatic t_idle;
      @(negedge clock_in);
      chk("selects", 8'h03, {6'h00, pins_out.select_primary_n,
         pins_out.select_secondary_n});
      chk("data_oe_out", 8'h00, {7'h00, data_oe_out});
   endtask
   task automatic t_fresh;
      rd_chk(11'h123, 8'h23 ^ 8'h5A);
      rd_chk(11'h7FE, 8'hFE ^ 8'h5A);
   endtask
   task automatic t_edges;
      issue(1'b1, 11'h000, 8'hC3);
      issue(1'b1, 11'h7FF, 8'h3C);
      rd_chk(11'h000, 8'hC3);
      rd_chk(11'h7FF, 8'h3C);
      rd_chk(11'h001, 8'h01 ^ 8'h5A);
   endtask
   task automatic t_overwrite;
      issue(1'b1, 11'h400, 8'hFF);
      issue(1'b1, 11'h400, 8'h00);
      rd_chk(11'h400, 8'h00);
      issue(1'b1, 11'h400, 8'hA5);
      rd_chk(11'h400, 8'hA5);
   endtask
   // reset cuts a write in its overlap; pins idle, then a clean read
   task automatic t_reset;
      issue(1'b1, 11'h055, 8'h99);
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_idle();
      chk("req_ready_out", 8'h01, {7'h00, req_ready_out});
      rd_chk(11'h0AA, 8'hAA ^ 8'h5A);
   endtask
   initial begin
      sys_rst_in = 1;
      req_valid_in = 0;
      req_in = '0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (6) @(posedge clock_in);
      sys_rst_in <= 0;
      t_idle();
      t_fresh();
      t_edges();
      t_overwrite();
      t_reset();
      results();
   end
endmodule
`default_nettype wire
